// file: ialu_ci_model.sv
// Purpose: Behavioural custom instruction logic on the far side.
// Assumes: Same clock as the core; delay set by the bench.
// Notes: Result shows the inverse of the last value while idle.
`timescale 1ns/10ps
`default_nettype none
module ialu_ci_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire ialu_pkg::ialu_ci_req_t ci_out,
  input wire logic [3:0] delay,
  output ialu_pkg::ialu_ci_rsp_t ci_in
);
  logic [3:0] cnt, next_cnt;
  logic [31:0] held, next_held, fresh;
  assign fresh = ci_out.dataa + (ci_out.datab ^ {24'h0, ci_out.n});
  always_comb begin
    next_cnt = cnt;
    next_held = held;
    if (ci_out.start) begin
      next_cnt = delay;
      next_held = fresh;
    end else if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      held <= 32'h0;
    end else begin
      cnt <= next_cnt;
      held <= next_held;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // A zero delay answers in the start cycle, the tightest the core takes.
  always_comb begin
    ci_in.done = (ci_out.start && delay == 4'h0) ||
      (!ci_out.start && cnt == 4'h1);
    ci_in.result = ~held;
    if (ci_out.start && delay == 4'h0) begin
      ci_in.result = fresh;
    end else if (ci_in.done) begin
      ci_in.result = held;
    end
  end
endmodule
`default_nettype wire

// file: ialu_core.sv
// Purpose: Integer ALU with multiply, divide, custom and float operations.
// Assumes: One request at a time while busy is low; custom logic on core_clk.
// Notes: Missing options answer with a trap instead of a result.
`timescale 1ns/10ps
`default_nettype none
module ialu_core #(
  parameter bit HAS_MULDIV = 1'b1,
  parameter bit HAS_FPU = 1'b1,
  parameter bit HAS_FPDIV = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire ialu_pkg::ialu_req_t req,
  output logic busy,
  output logic resp_valid,
  output ialu_pkg::ialu_resp_t resp,
  output ialu_pkg::ialu_ci_req_t ci_out,
  input wire ialu_pkg::ialu_ci_rsp_t ci_in
);

  //////////////////////////////////////////////////////////////////////
  // Returns {nan, inf, zero}; a zero exponent counts as zero.
  function automatic logic [2:0] fp_cls(input logic [31:0] x);
    logic ex1;
    ex1 = x[30:23] == ialu_pkg::FP_EXP_ONES;
    return {ex1 && x[22:0] != 23'h000000, ex1 && x[22:0] == 23'h000000,
            x[30:23] == 8'h00};
  endfunction

  // Rounds a mantissa with guard and sticky bits and packs the result.
  function automatic logic [31:0] fp_pack(input logic s,
                                          input logic signed [9:0] e,
                                          input logic [26:0] m);
    logic inc;
    logic [24:0] mr;
    logic signed [9:0] ee;
    inc = m[2] & (m[3] | m[1] | m[0]);
    mr = {1'b0, m[26:3]} + {24'h000000, inc};
    ee = e;
    if (mr[24]) begin
      mr = {1'b0, mr[24:1]};
      ee = ee + 10'sh001;
    end
    if (ee >= ialu_pkg::FP_EXP_INF) begin
      return {s, ialu_pkg::FP_EXP_ONES, 23'h000000};
    end
    if (ee <= 10'sh000) begin
      return {s, 31'h00000000};
    end
    return {s, ee[7:0], mr[22:0]};
  endfunction

  function automatic logic [31:0] fp_add(input logic [31:0] x,
                                         input logic [31:0] y);
    logic [2:0] cx, cy;
    logic bigx, sb, ss, st;
    logic [7:0] d;
    logic [26:0] mb, ms, tmp, m;
    logic [27:0] s;
    logic signed [9:0] e;
    cx = fp_cls(x);
    cy = fp_cls(y);
    if (cx[2] || cy[2] || (cx[1] && cy[1] && x[31] != y[31])) begin
      return ialu_pkg::FP_QNAN;
    end
    if (cx[1]) begin
      return x;
    end
    if (cy[1]) begin
      return y;
    end
    if (cx[0] && cy[0]) begin
      return {x[31] & y[31], 31'h00000000};
    end
    if (cx[0]) begin
      return y;
    end
    if (cy[0]) begin
      return x;
    end
    bigx = x[30:0] >= y[30:0];
    sb = bigx ? x[31] : y[31];
    ss = bigx ? y[31] : x[31];
    e = $signed({2'b00, bigx ? x[30:23] : y[30:23]});
    d = bigx ? x[30:23] - y[30:23] : y[30:23] - x[30:23];
    mb = {1'b1, bigx ? x[22:0] : y[22:0], 3'h0};
    ms = {1'b1, bigx ? y[22:0] : x[22:0], 3'h0};
    if (d > 8'h1a) begin
      ms = 27'h0000001;
    end else begin
      tmp = ms >> d;
      st = (tmp << d) != ms;
      ms = {tmp[26:1], tmp[0] | st};
    end
    if (sb == ss) begin
      s = {1'b0, mb} + {1'b0, ms};
      m = s[27] ? {s[27:2], s[1] | s[0]} : s[26:0];
      e = s[27] ? e + 10'sh001 : e;
    end else begin
      s = {1'b0, mb} - {1'b0, ms};
      if (s == 28'h0000000) begin
        return 32'h00000000;
      end
      m = s[26:0];
      for (int i = 0; i < 26; i++) begin
        if (!m[26]) begin
          m = {m[25:0], 1'b0};
          e = e - 10'sh001;
        end
      end
    end
    return fp_pack(sb, e, m);
  endfunction

  function automatic logic [31:0] fp_mul(input logic [31:0] x,
                                         input logic [31:0] y);
    logic [2:0] cx, cy;
    logic s;
    logic [47:0] p;
    logic signed [9:0] e;
    cx = fp_cls(x);
    cy = fp_cls(y);
    s = x[31] ^ y[31];
    if (cx[2] || cy[2] || (cx[1] && cy[0]) || (cy[1] && cx[0])) begin
      return ialu_pkg::FP_QNAN;
    end
    if (cx[1] || cy[1]) begin
      return {s, ialu_pkg::FP_EXP_ONES, 23'h000000};
    end
    if (cx[0] || cy[0]) begin
      return {s, 31'h00000000};
    end
    p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
    e = $signed({2'b00, x[30:23]}) + $signed({2'b00, y[30:23]})
        - ialu_pkg::FP_BIAS;
    if (p[47]) begin
      return fp_pack(s, e + 10'sh001, {p[47:22], |p[21:0]});
    end
    return fp_pack(s, e, {p[46:21], |p[20:0]});
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Single-cycle datapath.
  logic [31:0] alu_res;
  logic alu_trap;
  logic [65:0] prod;
  logic [63:0] rotl, rotr;
  logic [4:0] sh;

  always_comb begin
    sh = req.b[4:0] & ialu_pkg::SHIFT_MAX;
    prod = 66'($signed({(req.op == ialu_pkg::OP_MULXSS ||
                         req.op == ialu_pkg::OP_MULXSU) & req.a[31], req.a})
           * $signed({(req.op == ialu_pkg::OP_MULXSS) & req.b[31], req.b}));
    rotl = {req.a, req.a} << sh;
    rotr = {req.a, req.a} >> sh;
    alu_trap = 1'b0;
    alu_res = 32'h00000000;
    unique case (req.op)
      ialu_pkg::OP_ADD: alu_res = req.a + req.b;
      ialu_pkg::OP_SUB: alu_res = req.a - req.b;
      ialu_pkg::OP_MUL: alu_res = prod[31:0];
      ialu_pkg::OP_MULXSS, ialu_pkg::OP_MULXSU,
      ialu_pkg::OP_MULXUU: alu_res = prod[63:32];
      ialu_pkg::OP_CMPEQ: alu_res = {31'h0, req.a == req.b};
      ialu_pkg::OP_CMPNE: alu_res = {31'h0, req.a != req.b};
      ialu_pkg::OP_CMPGE:
        alu_res = {31'h0, $signed(req.a) >= $signed(req.b)};
      ialu_pkg::OP_CMPGEU: alu_res = {31'h0, req.a >= req.b};
      ialu_pkg::OP_CMPLT:
        alu_res = {31'h0, $signed(req.a) < $signed(req.b)};
      ialu_pkg::OP_CMPLTU: alu_res = {31'h0, req.a < req.b};
      ialu_pkg::OP_AND: alu_res = req.a & req.b;
      ialu_pkg::OP_OR: alu_res = req.a | req.b;
      ialu_pkg::OP_NOR: alu_res = ~(req.a | req.b);
      ialu_pkg::OP_XOR: alu_res = req.a ^ req.b;
      ialu_pkg::OP_SLL: alu_res = req.a << sh;
      ialu_pkg::OP_SRL: alu_res = req.a >> sh;
      ialu_pkg::OP_SRA: alu_res = $signed(req.a) >>> sh;
      ialu_pkg::OP_ROL: alu_res = rotl[63:32];
      ialu_pkg::OP_ROR: alu_res = rotr[31:0];
      ialu_pkg::OP_FADD: alu_res = fp_add(req.a, req.b);
      ialu_pkg::OP_FSUB: alu_res = fp_add(req.a, {~req.b[31], req.b[30:0]});
      ialu_pkg::OP_FMUL: alu_res = fp_mul(req.a, req.b);
      default: alu_res = 32'h00000000;
    endcase
    // A trap carries no result; the handler emulates in software.
    if (!HAS_MULDIV && (req.op inside {ialu_pkg::OP_MUL,
        ialu_pkg::OP_MULXSS, ialu_pkg::OP_MULXSU, ialu_pkg::OP_MULXUU,
        ialu_pkg::OP_DIV, ialu_pkg::OP_DIVU})) begin
      alu_trap = 1'b1;
    end
    if ((!HAS_FPU && req.op inside {ialu_pkg::OP_FADD, ialu_pkg::OP_FSUB,
        ialu_pkg::OP_FMUL, ialu_pkg::OP_FDIV}) ||
        (!HAS_FPDIV && req.op == ialu_pkg::OP_FDIV)) begin
      alu_trap = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sequencer for divides and custom instructions.
  ialu_pkg::ialu_state_t state, next_state;
  ialu_pkg::ialu_resp_t next_resp;
  ialu_pkg::ialu_ci_req_t next_ci;
  logic next_busy, next_resp_valid, div_go, next_div_go, neg, next_neg;
  logic [31:0] div_hi, next_div_hi, div_lo, next_div_lo;
  logic [32:0] div_den, next_div_den;
  logic signed [9:0] fexp, next_fexp;
  logic [2:0] ca, cb;
  logic [31:0] qv, abs_a, abs_b;
  logic div_done, div_rnz;

  ialu_divider u_div (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .start(div_go),
    .hi(div_hi),
    .lo(div_lo),
    .den(div_den),
    .done(div_done),
    .quo(qv),
    .rem_nz(div_rnz)
  );

  always_comb begin
    next_state = state;
    next_resp_valid = 1'b0;
    next_resp = resp;
    next_ci = ci_out;
    next_ci.start = 1'b0;
    next_div_go = 1'b0;
    next_div_hi = div_hi;
    next_div_lo = div_lo;
    next_div_den = div_den;
    next_neg = neg;
    next_fexp = fexp;
    ca = fp_cls(req.a);
    cb = fp_cls(req.b);
    abs_a = (req.op == ialu_pkg::OP_DIV && req.a[31]) ? -req.a : req.a;
    abs_b = (req.op == ialu_pkg::OP_DIV && req.b[31]) ? -req.b : req.b;
    unique case (state)
      ialu_pkg::ST_IDLE: begin
        if (req_valid) begin
          next_resp = '{alu_res, req.dest, !alu_trap, alu_trap};
          next_resp_valid = 1'b1;
          next_neg = req.a[31] ^ req.b[31];
          if (alu_trap) begin
            next_resp.result = 32'h00000000;
          end else if (req.op == ialu_pkg::OP_DIV ||
                       req.op == ialu_pkg::OP_DIVU) begin
            next_resp_valid = 1'b0;
            next_neg = req.op == ialu_pkg::OP_DIV && next_neg;
            next_div_hi = 32'h00000000;
            next_div_lo = abs_a;
            next_div_den = {1'b0, abs_b};
            next_div_go = 1'b1;
            next_state = ialu_pkg::ST_IDIV;
          end else if (req.op == ialu_pkg::OP_FDIV) begin
            if (ca[2] || cb[2] || (ca[1] && cb[1]) || (ca[0] && cb[0])) begin
              next_resp.result = ialu_pkg::FP_QNAN;
            end else if (ca[1] || cb[0]) begin
              next_resp.result = {next_neg, ialu_pkg::FP_EXP_ONES,
                                  23'h000000};
            end else if (ca[0] || cb[1]) begin
              next_resp.result = {next_neg, 31'h00000000};
            end else begin
              // Dividend below divisor: quotient lands in [2^30, 2^32).
              next_resp_valid = 1'b0;
              next_div_hi = {8'h00, 1'b1, req.a[22:0]};
              next_div_lo = 32'h00000000;
              next_div_den = {8'h00, 1'b1, req.b[22:0], 1'b0};
              next_fexp = $signed({2'b00, req.a[30:23]})
                          - $signed({2'b00, req.b[30:23]})
                          + ialu_pkg::FP_BIAS;
              next_div_go = 1'b1;
              next_state = ialu_pkg::ST_FDIV;
            end
          end else if (req.op == ialu_pkg::OP_CUSTOM) begin
            next_resp_valid = 1'b0;
            next_ci = '{1'b1, req.ci_n, req.a, req.b};
            next_state = ialu_pkg::ST_CUSTOM;
          end
        end
      end
      ialu_pkg::ST_IDIV: begin
        if (div_done) begin
          next_resp.result = neg ? -qv : qv;
          next_resp_valid = 1'b1;
          next_state = ialu_pkg::ST_IDLE;
        end
      end
      ialu_pkg::ST_FDIV: begin
        if (div_done) begin
          next_resp.result = qv[31] ?
            fp_pack(neg, fexp, {qv[31:6], (|qv[5:0]) | div_rnz}) :
            fp_pack(neg, fexp - 10'sh001,
                    {qv[30:5], (|qv[4:0]) | div_rnz});
          next_resp_valid = 1'b1;
          next_state = ialu_pkg::ST_IDLE;
        end
      end
      ialu_pkg::ST_CUSTOM: begin
        if (ci_in.done) begin
          next_resp.result = ci_in.result;
          next_resp_valid = 1'b1;
          next_state = ialu_pkg::ST_IDLE;
        end
      end
    endcase
    next_busy = next_state != ialu_pkg::ST_IDLE;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ialu_pkg::ST_IDLE;
      busy <= 1'b0;
      resp_valid <= 1'b0;
      resp <= '0;
      ci_out <= '0;
      div_go <= 1'b0;
      div_hi <= '0;
      div_lo <= '0;
      div_den <= '0;
      neg <= 1'b0;
      fexp <= '0;
    end else begin
      state <= next_state;
      busy <= next_busy;
      resp_valid <= next_resp_valid;
      resp <= next_resp;
      ci_out <= next_ci;
      div_go <= next_div_go;
      div_hi <= next_div_hi;
      div_lo <= next_div_lo;
      div_den <= next_div_den;
      neg <= next_neg;
      fexp <= next_fexp;
    end
  end

endmodule
`default_nettype wire

// file: ialu_core_properties.sv
// Purpose: Port-level assertions for the integer and float unit.
// Assumes: Single core clock, asynchronous active-low reset.
// Notes: Bound to every core instance with its option parameters.
`timescale 1ns/10ps
`default_nettype none
module ialu_core_properties #(
  parameter bit HAS_MULDIV = 1'b1,
  parameter bit HAS_FPU = 1'b1,
  parameter bit HAS_FPDIV = 1'b1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire ialu_pkg::ialu_req_t req,
  input wire logic busy,
  input wire logic resp_valid,
  input wire ialu_pkg::ialu_resp_t resp,
  input wire ialu_pkg::ialu_ci_req_t ci_out,
  input wire ialu_pkg::ialu_ci_rsp_t ci_in
);
  logic take, pend, ci_wait, next_ci_wait, fp_last, next_fp_last;
  assign take = req_valid && !busy;
  assign pend = ci_wait || ci_out.start;
  always_comb begin
    next_ci_wait = pend && !ci_in.done;
    next_fp_last = fp_last;
    if (take) begin
      next_fp_last = req.op inside {[ialu_pkg::OP_FADD:ialu_pkg::OP_FDIV]};
    end
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ci_wait <= 1'b0;
      fp_last <= 1'b0;
    end else begin
      ci_wait <= next_ci_wait;
      fp_last <= next_fp_last;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_div_take;
    take && HAS_MULDIV && req.op == ialu_pkg::OP_DIVU && req.b != 32'h0;
  endsequence
  sequence s_div_wait;
    (busy && !resp_valid) [*8];
  endsequence
  alu_add_a: assert property (
    take && req.op == ialu_pkg::OP_ADD |=> resp_valid && resp.we &&
    resp.result == $past(req.a) + $past(req.b))
    else $error("add result wrong");
  cmp_less_a: assert property (
    take && req.op == ialu_pkg::OP_CMPLT |=> resp.result ==
    {31'h0, $signed($past(req.a)) < $signed($past(req.b))})
    else $error("signed compare wrong");
  shift_sra_a: assert property (
    take && req.op == ialu_pkg::OP_SRA |=> resp.result ==
    $unsigned($signed($past(req.a)) >>> $past(req.b[4:0])))
    else $error("arithmetic shift wrong");
  div_latency_a: assert property (
    s_div_take |=> s_div_wait ##27 (resp_valid && !busy &&
    resp.result == $past(req.a, 35) / $past(req.b, 35)))
    else $error("divide timing or quotient wrong");
  trap_shape_a: assert property (
    resp_valid && resp.trap |-> !resp.we && resp.result == 32'h0)
    else $error("trap response not clean");
  opt_trap_a: assert property (
    take && ((!HAS_MULDIV && req.op inside
    {[ialu_pkg::OP_MUL:ialu_pkg::OP_DIVU]}) || (!HAS_FPDIV &&
    req.op == ialu_pkg::OP_FDIV) || (!HAS_FPU && req.op inside
    {[ialu_pkg::OP_FADD:ialu_pkg::OP_FDIV]})) |=> resp_valid && resp.trap)
    else $error("absent option did not trap");
  ci_start_a: assert property (
    take && req.op == ialu_pkg::OP_CUSTOM |=> ci_out.start && busy &&
    ci_out.dataa == $past(req.a) && ci_out.n == $past(req.ci_n))
    else $error("custom start wrong");
  ci_pulse_a: assert property (
    ci_out.start |=> !ci_out.start)
    else $error("custom start longer than one cycle");
  ci_done_a: assert property (
    pend && ci_in.done |=> resp_valid && !busy &&
    resp.result == $past(ci_in.result))
    else $error("custom result not returned");
  fp_norm_a: assert property (
    resp_valid && fp_last && !resp.trap |-> !(resp.result[30:23] == 8'h00
    && resp.result[22:0] != 23'h0))
    else $error("subnormal float produced");
endmodule
bind ialu_core ialu_core_properties #(.HAS_MULDIV(HAS_MULDIV),
  .HAS_FPU(HAS_FPU), .HAS_FPDIV(HAS_FPDIV)) u_props (.core_clk, .arst_n,
  .req_valid, .req, .busy, .resp_valid, .resp, .ci_out, .ci_in);
`default_nettype wire

// file: ialu_divider.sv
// Purpose: Restoring divider, one quotient bit per clock.
// Assumes: Dividend is {hi, lo} with hi below the divisor.
// Notes: Thirty-two steps; done pulses from a flop.
`timescale 1ns/10ps
`default_nettype none
module ialu_divider (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [31:0] hi,
  input wire logic [31:0] lo,
  input wire logic [32:0] den,
  output logic done,
  output logic [31:0] quo,
  output logic rem_nz
);

  logic [32:0] rem, next_rem, dvs, next_dvs;
  logic [31:0] next_quo, shf, next_shf;
  logic [5:0] cnt, next_cnt;
  logic next_done, next_rem_nz;
  logic [32:0] trial;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    next_rem = rem;
    next_dvs = dvs;
    next_quo = quo;
    next_shf = shf;
    next_cnt = cnt;
    next_done = 1'b0;
    next_rem_nz = rem_nz;
    trial = {rem[31:0], shf[31]};
    if (start) begin
      next_rem = {1'b0, hi};
      next_shf = lo;
      next_dvs = den;
      next_cnt = ialu_pkg::DIV_STEPS;
    end else if (cnt != 6'h00) begin
      next_shf = {shf[30:0], 1'b0};
      next_cnt = cnt - 6'h01;
      if (trial >= dvs) begin
        next_rem = trial - dvs;
        next_quo = {quo[30:0], 1'b1};
      end else begin
        next_rem = trial;
        next_quo = {quo[30:0], 1'b0};
      end
      if (cnt == 6'h01) begin
        next_done = 1'b1;
        next_rem_nz = next_rem != 33'h000000000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rem <= '0;
      dvs <= '0;
      quo <= '0;
      shf <= '0;
      cnt <= '0;
      done <= 1'b0;
      rem_nz <= 1'b0;
    end else begin
      rem <= next_rem;
      dvs <= next_dvs;
      quo <= next_quo;
      shf <= next_shf;
      cnt <= next_cnt;
      done <= next_done;
      rem_nz <= next_rem_nz;
    end
  end

endmodule
`default_nettype wire

// file: ialu_pkg.sv
// Purpose: Shared types and constants of the integer and float unit.
// Assumes: One core clock, asynchronous active-low reset.
// Notes: Floats are single precision; subnormals are flushed to zero.
package ialu_pkg;

  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_MUL, OP_MULXSS, OP_MULXSU, OP_MULXUU,
    OP_DIV, OP_DIVU, OP_CMPEQ, OP_CMPNE, OP_CMPGE, OP_CMPGEU,
    OP_CMPLT, OP_CMPLTU, OP_AND, OP_OR, OP_NOR, OP_XOR,
    OP_SLL, OP_SRL, OP_SRA, OP_ROL, OP_ROR, OP_CUSTOM,
    OP_FADD, OP_FSUB, OP_FMUL, OP_FDIV
  } ialu_op_t;

  typedef enum {ST_IDLE, ST_IDIV, ST_FDIV, ST_CUSTOM} ialu_state_t;

  typedef struct packed {
    ialu_op_t op;
    logic [7:0] ci_n;
    logic [4:0] dest;
    logic [31:0] a;
    logic [31:0] b;
  } ialu_req_t;

  typedef struct packed {
    logic [31:0] result;
    logic [4:0] dest;
    logic we;
    logic trap;
  } ialu_resp_t;

  typedef struct packed {
    logic start;
    logic [7:0] n;
    logic [31:0] dataa;
    logic [31:0] datab;
  } ialu_ci_req_t;

  typedef struct packed {
    logic done;
    logic [31:0] result;
  } ialu_ci_rsp_t;

  localparam logic [5:0] DIV_STEPS = 6'h20;
  localparam logic [31:0] FP_QNAN = 32'h7fc00000;
  localparam logic signed [9:0] FP_BIAS = 10'sh07f;
  localparam logic signed [9:0] FP_EXP_INF = 10'sh0ff;
  localparam logic [7:0] FP_EXP_ONES = 8'hff;
  localparam logic [4:0] SHIFT_MAX = 5'h1f;

endpackage

// file: tb_integer_alu_float_extension.sv
// Purpose: Self-checking bench for the integer and float unit.
// Assumes: A full core, a core without multiply, divide or fdiv, and one without multiply, divide or float.
// Notes: Both lean cores loop their custom done back to their start.
`timescale 1ns/10ps
`default_nettype none
module tb_integer_alu_float_extension;
  logic core_clk, arst_n, req_valid, busy, resp_valid, l_busy, l_valid;
  ialu_pkg::ialu_req_t req;
  logic n_valid;
  ialu_pkg::ialu_resp_t resp, l_resp, n_resp;
  ialu_pkg::ialu_ci_req_t ci_out, l_ci, n_ci;
  ialu_pkg::ialu_ci_rsp_t ci_in, l_in, n_in;
  logic [3:0] delay;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  assign l_in = {l_ci.start, 32'h0};
  assign n_in = {n_ci.start, 32'h0};
  ialu_core u_dut (.core_clk, .arst_n, .req_valid, .req, .busy,
    .resp_valid, .resp, .ci_out, .ci_in);
  ialu_core #(.HAS_MULDIV(1'b0), .HAS_FPDIV(1'b0)) u_dut_lite (.core_clk,
    .arst_n, .req_valid, .req, .busy(l_busy), .resp_valid(l_valid),
    .resp(l_resp), .ci_out(l_ci), .ci_in(l_in));
  // Without float hardware every float operation must trap.
  ialu_core #(.HAS_MULDIV(1'b0), .HAS_FPU(1'b0)) u_dut_nofp (.core_clk,
    .arst_n, .req_valid, .req, .busy(), .resp_valid(n_valid),
    .resp(n_resp), .ci_out(n_ci), .ci_in(n_in));
  ialu_ci_model u_ci (.core_clk, .arst_n, .ci_out, .delay, .ci_in);
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // All three cores see the request; a lean trap may land before the answer.
  task automatic run(input ialu_pkg::ialu_op_t code, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] exp, input logic lt);
    logic m_seen, l_seen, l_trap, n_trap;
    logic [31:0] got, l_got, flags;
    m_seen = 1'b0;
    l_seen = 1'b0;
    got = 'x;
    l_got = 'x;
    l_trap = 'x;
    n_trap = 'x;
    flags = 'x;
    @(posedge core_clk);
    req_valid <= 1'b1;
    req <= '{code, 8'h5a, 5'h07, a, b};
    @(posedge core_clk);
    req_valid <= 1'b0;
    for (int n = 0; n < 60 && !(m_seen && l_seen); n++) begin
      @(negedge core_clk);
      if (n_valid)
        n_trap = n_resp.trap;
      if (l_valid) begin
        l_seen = 1'b1;
        l_trap = l_resp.trap;
        l_got = l_resp.result;
      end
      if (resp_valid) begin
        m_seen = 1'b1;
        got = resp.result;
        flags = {25'h0, resp.we, resp.trap, resp.dest};
      end
    end
    chk(got, exp);
    chk(flags, {25'h0, 2'b10, 5'h07});
    chk({31'h0, l_trap}, {31'h0, lt});
    chk({31'h0, n_trap}, {31'h0, lt || (code inside
      {[ialu_pkg::OP_FADD:ialu_pkg::OP_FDIV]})});
    if (!lt && code != ialu_pkg::OP_CUSTOM)
      chk(l_got, exp);
  endtask
  task automatic fp(input ialu_pkg::ialu_op_t code, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] exp);
    run(code, a, b, exp, code == ialu_pkg::OP_FDIV);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_arith();
    logic [31:0] a, b;
    a = 32'hfffffff9;
    b = 32'h80000002;
    run(ialu_pkg::OP_ADD, a, b, a + b, 1'b0);
    run(ialu_pkg::OP_SUB, a, b, a - b, 1'b0);
    run(ialu_pkg::OP_MUL, a, b, 32'h7ffffff2, 1'b1);
    run(ialu_pkg::OP_MULXSS, a, b, 32'h00000003, 1'b1);
    run(ialu_pkg::OP_MULXSU, a, b, 32'hfffffffc, 1'b1);
    run(ialu_pkg::OP_MULXUU, a, b, 32'h7ffffffe, 1'b1);
    b = 32'h00000002;
    run(ialu_pkg::OP_DIV, a, b, 32'hfffffffd, 1'b1);
    run(ialu_pkg::OP_DIVU, a, b, 32'h7ffffffc, 1'b1);
    run(ialu_pkg::OP_DIVU, a, 32'h0, 32'hffffffff, 1'b1);
    a = 32'h80000000;
    run(ialu_pkg::OP_DIV, a, 32'hffffffff, a, 1'b1);
    $display("arith test done");
  endtask
  task automatic t_cmp_logic();
    logic [31:0] a, b;
    a = 32'hffffffff;
    b = 32'h00000001;
    run(ialu_pkg::OP_CMPEQ, a, b, 32'h0, 1'b0);
    run(ialu_pkg::OP_CMPNE, a, b, 32'h1, 1'b0);
    run(ialu_pkg::OP_CMPGE, a, b, 32'h0, 1'b0);
    run(ialu_pkg::OP_CMPGEU, a, b, 32'h1, 1'b0);
    run(ialu_pkg::OP_CMPLT, a, b, 32'h1, 1'b0);
    run(ialu_pkg::OP_CMPLTU, a, b, 32'h0, 1'b0);
    a = 32'hf0f0cc33;
    b = 32'hff00aa55;
    run(ialu_pkg::OP_AND, a, b, 32'hf0008811, 1'b0);
    run(ialu_pkg::OP_OR, a, b, 32'hfff0ee77, 1'b0);
    run(ialu_pkg::OP_NOR, a, b, 32'h000f1188, 1'b0);
    run(ialu_pkg::OP_XOR, a, b, 32'h0ff06666, 1'b0);
    $display("compare and logic test done");
  endtask
  // Upper distance bits are set to prove only five bits count.
  task automatic t_shift();
    logic [31:0] a, b;
    a = 32'h80000f01;
    for (int s = 0; s < 32; s++) begin
      b = 32'hffffffe0 | s;
      run(ialu_pkg::OP_SLL, a, b, a << s, 1'b0);
      run(ialu_pkg::OP_SRL, a, b, a >> s, 1'b0);
      run(ialu_pkg::OP_SRA, a, b, $signed(a) >>> s, 1'b0);
      run(ialu_pkg::OP_ROL, a, b, (a << s) | (a >> (32 - s)), 1'b0);
      run(ialu_pkg::OP_ROR, a, b, (a >> s) | (a << (32 - s)), 1'b0);
    end
    $display("shift test done");
  endtask
  task automatic t_custom();
    for (int d = 0; d < 8; d += 6) begin
      delay <= d[3:0];
      run(ialu_pkg::OP_CUSTOM, 32'h12345678, 32'h0f0f0f0f, 32'h214365cd,
        1'b0);
    end
    $display("custom test done");
  endtask
  task automatic t_float();
    fp(ialu_pkg::OP_FADD, 32'h3f800000, 32'h40000000, 32'h40400000);
    fp(ialu_pkg::OP_FSUB, 32'h40400000, 32'h3f800000, 32'h40000000);
    fp(ialu_pkg::OP_FMUL, 32'h40000000, 32'h40400000, 32'h40c00000);
    fp(ialu_pkg::OP_FDIV, 32'h40c00000, 32'h40000000, 32'h40400000);
    fp(ialu_pkg::OP_FSUB, 32'h3f800000, 32'h3f800000, 32'h00000000);
    fp(ialu_pkg::OP_FADD, 32'h7f800000, 32'hff800000, 32'h7fc00000);
    fp(ialu_pkg::OP_FMUL, 32'h7f800000, 32'h00000000, 32'h7fc00000);
    fp(ialu_pkg::OP_FDIV, 32'h00000000, 32'h00000000, 32'h7fc00000);
    fp(ialu_pkg::OP_FDIV, 32'hbf800000, 32'h00000000, 32'hff800000);
    fp(ialu_pkg::OP_FMUL, 32'h7f7fffff, 32'h40000000, 32'h7f800000);
    fp(ialu_pkg::OP_FMUL, 32'hff7fffff, 32'h40000000, 32'hff800000);
    fp(ialu_pkg::OP_FADD, 32'h3f800000, 32'h30800000, 32'h3f800000);
    fp(ialu_pkg::OP_FMUL, 32'h80800000, 32'h00800000, 32'h80000000);
    fp(ialu_pkg::OP_FADD, 32'h00000001, 32'h00000000, 32'h00000000);
    fp(ialu_pkg::OP_FMUL, 32'h00400000, 32'h7f000000, 32'h00000000);
    fp(ialu_pkg::OP_FADD, 32'h7fc00000, 32'h3f800000, 32'h7fc00000);
    fp(ialu_pkg::OP_FADD, 32'h3f800000, 32'h33800000, 32'h3f800000);
    fp(ialu_pkg::OP_FADD, 32'h3f800001, 32'h33800000, 32'h3f800002);
    $display("float test done");
  endtask
  initial begin
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    delay = 4'h0;
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    t_arith();
    t_cmp_logic();
    t_shift();
    t_custom();
    t_float();
    results();
  end
endmodule
`default_nettype wire
